/* hdl/tsq_defs.vh */
// Register map, field layout and timing constants of the trigger sequencer
`ifndef TSQ_DEFS_VH
`define TSQ_DEFS_VH

`define TSQ_OFF_CTRL      12'h000
`define TSQ_OFF_SDLY      12'h004
`define TSQ_OFF_C0LIM     12'h008
`define TSQ_OFF_RUN       12'h00c
`define TSQ_OFF_STAT      12'h010

`define TSQ_CLKSEL_HI     15
`define TSQ_CLKSEL_LO     13
`define TSQ_DIV_HI        12
`define TSQ_DIV_LO        8
`define TSQ_PWD_HI        7
`define TSQ_PWD_LO        4
`define TSQ_WDT_HI        2
`define TSQ_WDT_LO        0
`define TSQ_CTRL_MASK     16'hfff7

`define TSQ_RUN_ON        0
`define TSQ_RUN_GO        1

`define TSQ_RST_16        16'h0000
`define TSQ_WDT_BASE      10'h004

`define TSQ_RESP_OKAY     2'b00
`define TSQ_RESP_SLVERR   2'b10

`endif

/* hdl/tsq_timing.v */
// Trigger sequencer timing and limit registers with AXI4-Lite slave
// How it works
// RULE1: Each trigger pulse lasts pulse-width field plus one sequencer clocks.
// RULE2: Watchdog code 0 disables; codes 1..7 give 8 to 512 clocks.
// RULE3: Step delay register holds extra sequencer clocks per step.
// RULE4: One base clock always added: step delay equals value plus one.
// RULE5: Step delay and counter-0 limit ignore writes while module on and run.
// RULE6: Counter-0 limit gives jump loop count or counter 0 terminal value.
// RULE7: Clock source from 3-bit select, 6 and 7 reserved, divide by N+1.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tsq_defs.vh"

module tsq_timing #(
	parameter NSRC = 6
) (
	// Clock and reset
	input  wire            mclk,
	input  wire            resetn,
	// AXI4-Lite write address
	input  wire [11:0]     s_axi_awaddr,
	input  wire            s_axi_awvalid,
	output wire            s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]     s_axi_wdata,
	input  wire [3:0]      s_axi_wstrb,
	input  wire            s_axi_wvalid,
	output wire            s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]      s_axi_bresp,
	output reg             s_axi_bvalid,
	input  wire            s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0]     s_axi_araddr,
	input  wire            s_axi_arvalid,
	output wire            s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]     s_axi_rdata,
	output reg  [1:0]      s_axi_rresp,
	output reg             s_axi_rvalid,
	input  wire            s_axi_rready,
	// Clock source enables, one per selectable source
	input  wire [NSRC-1:0] src_tick,
	// Step engine handshake
	input  wire            step_start,
	input  wire            wait_start,
	input  wire            wait_done,
	input  wire            trig_req,
	input  wire            c0_load,
	input  wire            c0_inc,
	// Step engine results
	output reg             seq_tick,
	output reg             step_done,
	output reg             wdt_timeout,
	output reg             trig_pulse,
	output reg             c0_at_limit,
	output reg  [15:0]     c0_count
);

////////////////////////////////////////////////////////////////////////
reg  [15:0] ctrl_q;
reg  [15:0] sdly_q;
reg  [15:0] c0lim_q;
reg  [1:0]  run_q;
reg  [11:0] awaddr_q;
reg  [31:0] wdata_q;
reg  [3:0]  wstrb_q;
reg         aw_have_q;
reg         w_have_q;

wire locked = run_q[`TSQ_RUN_ON] & run_q[`TSQ_RUN_GO];

function known;
	input [11:0] a;
	begin
		known = (a == `TSQ_OFF_CTRL) || (a == `TSQ_OFF_SDLY) ||
			(a == `TSQ_OFF_C0LIM) || (a == `TSQ_OFF_RUN) ||
			(a == `TSQ_OFF_STAT);
	end
endfunction

function [15:0] merge16;
	input [15:0] old;
	input [31:0] d;
	input [3:0]  s;
	begin
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	end
endfunction

assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire aw_fire = s_axi_awvalid & s_axi_awready;
wire w_fire  = s_axi_wvalid & s_axi_wready;
wire aw_ok   = aw_have_q | aw_fire;
wire w_ok    = w_have_q | w_fire;
wire [11:0] wa  = aw_have_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wd  = w_have_q ? wdata_q : s_axi_wdata;
wire [3:0]  ws  = w_have_q ? wstrb_q : s_axi_wstrb;
wire do_wr = aw_ok & w_ok;

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		ctrl_q       <= `TSQ_RST_16;
		sdly_q       <= `TSQ_RST_16;
		c0lim_q      <= `TSQ_RST_16;
		run_q        <= 2'b00;
		awaddr_q     <= 12'h000;
		wdata_q      <= 32'h00000000;
		wstrb_q      <= 4'h0;
		aw_have_q    <= 1'b0;
		w_have_q     <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= `TSQ_RESP_OKAY;
	end else begin
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (do_wr) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= known(wa) ? `TSQ_RESP_OKAY : `TSQ_RESP_SLVERR;
			case (wa)
			`TSQ_OFF_CTRL:
				ctrl_q <= merge16(ctrl_q, wd, ws) & `TSQ_CTRL_MASK;
			`TSQ_OFF_SDLY:
				if (!locked) sdly_q <= merge16(sdly_q, wd, ws); // RULE5
			`TSQ_OFF_C0LIM:
				if (!locked) c0lim_q <= merge16(c0lim_q, wd, ws); // RULE5
			`TSQ_OFF_RUN:
				if (ws[0]) run_q <= wd[1:0];
			default: begin
			end
			endcase
		end else begin
			if (aw_fire) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Sequencer clock as an enable; one mclk per source tick at most
wire [2:0] clk_sel = ctrl_q[`TSQ_CLKSEL_HI:`TSQ_CLKSEL_LO];
wire [4:0] div_val = ctrl_q[`TSQ_DIV_HI:`TSQ_DIV_LO];
wire [3:0] pwd_val = ctrl_q[`TSQ_PWD_HI:`TSQ_PWD_LO];
wire [2:0] wdt_sel = ctrl_q[`TSQ_WDT_HI:`TSQ_WDT_LO];
reg  [4:0] div_q;
wire src_en = (clk_sel < NSRC) ? src_tick[clk_sel] : 1'b0; // RULE7
wire tick   = src_en && (div_q == div_val); // RULE7

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		div_q    <= 5'h00;
		seq_tick <= 1'b0;
	end else begin
		seq_tick <= tick;
		if (tick)
			div_q <= 5'h00;
		else if (src_en)
			div_q <= div_q + 5'h01;
		else if (div_q > div_val)
			div_q <= 5'h00;
	end
end

////////////////////////////////////////////////////////////////////////
reg  [16:0] sd_q;
reg         sd_busy_q;
reg  [3:0]  pw_q;
reg  [9:0]  wd_q;
reg         wd_busy_q;
wire [9:0]  wd_limit = `TSQ_WDT_BASE << wdt_sel; // RULE2

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		sd_q        <= 17'h00000;
		sd_busy_q   <= 1'b0;
		step_done   <= 1'b0;
		pw_q        <= 4'h0;
		trig_pulse  <= 1'b0;
		wd_q        <= 10'h000;
		wd_busy_q   <= 1'b0;
		wdt_timeout <= 1'b0;
		c0_count    <= 16'h0000;
		c0_at_limit <= 1'b0;
	end else begin
		step_done   <= 1'b0;
		wdt_timeout <= 1'b0;
		// Step delay counts value plus one sequencer clocks
		if (step_start && locked) begin
			sd_busy_q <= 1'b1;
			sd_q      <= {1'b0, sdly_q} + 17'h00001; // RULE3 RULE4
		end else if (sd_busy_q && tick) begin
			if (sd_q == 17'h00001) begin
				sd_busy_q <= 1'b0;
				step_done <= 1'b1;
			end
			sd_q <= sd_q - 17'h00001;
		end
		// Pulse held pwd+1 ticks; a new request restarts it
		if (trig_req && tick) begin
			trig_pulse <= 1'b1;
			pw_q       <= pwd_val; // RULE1
		end else if (trig_pulse && tick) begin
			if (pw_q == 4'h0)
				trig_pulse <= 1'b0; // RULE1
			else
				pw_q <= pw_q - 4'h1;
		end
		// Watchdog guards a wait; disabled by code zero
		if (wait_done || wdt_sel == 3'b000 || !locked) begin
			wd_busy_q <= 1'b0;
		end else if (wait_start) begin
			wd_busy_q <= 1'b1;
			wd_q      <= 10'h000;
		end else if (wd_busy_q && tick) begin
			if (wd_q + 10'h001 == wd_limit) begin
				wd_busy_q   <= 1'b0;
				wdt_timeout <= 1'b1; // RULE2
			end
			wd_q <= wd_q + 10'h001;
		end
		// Counter 0 against its limit, also the jump loop count
		if (c0_load)
			c0_count <= 16'h0000;
		else if (c0_inc && tick && !c0_at_limit)
			c0_count <= c0_count + 16'h0001;
		c0_at_limit <= (c0_count == c0lim_q); // RULE6
	end
end

////////////////////////////////////////////////////////////////////////
// Read channel, one cycle latency
always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h00000000;
		s_axi_rresp  <= `TSQ_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp  <= known(s_axi_araddr) ? `TSQ_RESP_OKAY :
			`TSQ_RESP_SLVERR;
		case (s_axi_araddr)
		`TSQ_OFF_CTRL:  s_axi_rdata <= {16'h0000, ctrl_q};
		`TSQ_OFF_SDLY:  s_axi_rdata <= {16'h0000, sdly_q};
		`TSQ_OFF_C0LIM: s_axi_rdata <= {16'h0000, c0lim_q};
		`TSQ_OFF_RUN:   s_axi_rdata <= {30'h0, run_q};
		`TSQ_OFF_STAT:  s_axi_rdata <= {12'h000, sd_busy_q, wd_busy_q,
			trig_pulse, c0_at_limit, c0_count};
		default:        s_axi_rdata <= 32'h00000000;
		endcase
	end else if (s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule

/* testbench/tsq_periph_model.sv */
// Trigger receiver model: measures each trigger pulse in mclk cycles
`timescale 1ns/1ns
module tsq_periph_model (
	// Clock and trigger input
	input  wire       mclk,
	input  wire       trig_pulse,
	// Width of the last complete pulse
	output reg  [7:0] width
);
	reg [7:0] run_q = 8'h00;
	initial width = 8'h00;
	// Width latched on the first mclk edge after the pulse falls
	always @(posedge mclk) begin
		if (trig_pulse)
			run_q <= run_q + 8'h01;
		else if (run_q != 8'h00) begin
			width <= run_q;
			run_q <= 8'h00;
		end
	end
endmodule

/* testbench/tsq_timing_asserts.sv */
// Bus and timing checker for the trigger sequencer
`timescale 1ns/1ns
module tsq_timing_asserts #(
	parameter NSRC = 6
) (
	input wire            mclk,
	input wire            resetn,
	input wire            s_axi_awready,
	input wire            s_axi_wready,
	input wire [1:0]      s_axi_bresp,
	input wire            s_axi_bvalid,
	input wire            s_axi_bready,
	input wire            s_axi_arready,
	input wire [31:0]     s_axi_rdata,
	input wire            s_axi_rvalid,
	input wire            s_axi_rready,
	input wire [NSRC-1:0] src_tick,
	input wire            wait_start,
	input wire            seq_tick,
	input wire            wdt_timeout,
	input wire            trig_pulse
);
	// Ticks seen during a pulse; slack of one for tick alignment
	reg [4:0] hi_q;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			hi_q <= 5'h00;
		else
			hi_q <= !trig_pulse ? 5'h00 : hi_q + {4'h0, seq_tick};
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
	AST_W_BLOCK: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken early");
	AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken early");
	AST_NO_SRC: assert property ($past(src_tick) == 0 |-> !seq_tick)
		else $error("tick without source");
	AST_WDT_MIN: assert property (wait_start |=> !wdt_timeout [*7])
		else $error("watchdog too early");
	AST_PULSE_MAX: assert property (trig_pulse |-> hi_q < 5'h11)
		else $error("trigger pulse too long");
endmodule
bind tsq_timing tsq_timing_asserts #(.NSRC(NSRC)) i_tsq_timing_asserts (.*);

/* testbench/test_tsq_timing.sv */
// Self-checking bench for the trigger sequencer timing block
`timescale 1ns/1ns
`include "tsq_defs.vh"
module test_tsq_timing;
	reg         mclk = 1'h0, resetn = 1'h0;
	reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	reg         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	reg         s_axi_rready = 1'h0, wait_done = 1'h0;
	reg  [5:0]  src_tick = 6'h3f;
	reg         step_start = 1'h0, wait_start = 1'h0, trig_req = 1'h0;
	reg         c0_load = 1'h0, c0_inc = 1'h0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire        s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        seq_tick, step_done, wdt_timeout, trig_pulse, c0_at_limit;
	wire [15:0] c0_count;
	wire [7:0]  width;
	integer     bad_count = 0, n_tests = 0, ca, cb, i;
	reg  [15:0] v;
	reg  [1:0]  rsp;
	tsq_timing #(.NSRC(6)) i_tsq_timing (.*);
	tsq_periph_model i_tsq_periph_model (.mclk(mclk), .trig_pulse(trig_pulse),
		.width(width));
	always #2 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	end endtask
	task wr(input [11:0] a, input [15:0] d);
	begin
		s_axi_awaddr <= a; s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
		fork
			begin do @(posedge mclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'h0; end
			begin do @(posedge mclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'h0; end
		join
		// Ready raised late so the slave must hold its answer
		@(posedge mclk); s_axi_bready <= 1'h1;
		do @(posedge mclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0; rsp = s_axi_bresp;
	end endtask
	task rd(input [11:0] a);
	begin
		s_axi_araddr <= a; s_axi_arvalid <= 1'h1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		@(posedge mclk); s_axi_rready <= 1'h1;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0; v = s_axi_rdata[15:0]; rsp = s_axi_rresp;
	end endtask
	// Cycles from a strobe to its result; capped at 600
	task meas(input w, output integer c);
	begin
		if (w) wait_start <= 1'h1; else step_start <= 1'h1;
		@(posedge mclk); wait_start <= 1'h0; step_start <= 1'h0; c = 0;
		while (!(w ? wdt_timeout : step_done) && c < 600) begin
			@(posedge mclk); c = c + 1;
		end
	end endtask
	task pulse(input [15:0] c, input [3:0] p);
	begin
		wr(`TSQ_OFF_CTRL, c);
		if (p == 4'h0) c0_load <= 1'h1; else if (p == 4'h1) c0_inc <= 1'h1;
		else trig_req <= 1'h1;
		@(posedge mclk); c0_load <= 1'h0; c0_inc <= 1'h0; trig_req <= 1'h0;
		repeat (24) @(posedge mclk);
	end endtask
	task ticks(input [15:0] c, input [5:0] s, input integer e);
		integer n;
	begin
		wr(`TSQ_OFF_CTRL, c); src_tick <= s; repeat (4) @(posedge mclk);
		n = 0;
		repeat (40) begin @(posedge mclk); n = n + seq_tick; end
		chk(n, e);
	end endtask
	task report_and_stop;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
		for (i = 0; i < 3; i = i + 1) begin
			rd(i * 4); chk(v, 0);
		end
		rd(12'h020); chk(rsp, `TSQ_RESP_SLVERR);
		wr(12'h020, 16'h0000); chk(rsp, `TSQ_RESP_SLVERR);
		wr(`TSQ_OFF_CTRL, 16'hffff); rd(`TSQ_OFF_CTRL); chk(v, 16'hfff7);
		wr(`TSQ_OFF_CTRL, 16'h00f1); wr(`TSQ_OFF_RUN, 16'h0003);
		meas(0, ca);
		wr(`TSQ_OFF_RUN, 16'h0000); wr(`TSQ_OFF_SDLY, 16'h0003);
		wr(`TSQ_OFF_RUN, 16'h0003); meas(0, cb);
		chk(cb - ca, 3);
		wr(`TSQ_OFF_SDLY, 16'h0009); wr(`TSQ_OFF_C0LIM, 16'h0005);
		chk(rsp, `TSQ_RESP_OKAY);
		rd(`TSQ_OFF_SDLY); chk(v, 3);
		rd(`TSQ_OFF_C0LIM); chk(v, 0);
		meas(1, ca); pulse(16'h00f2, 4'h2); meas(1, cb);
		chk(cb - ca, 8);
		chk(width, 16);
		// A wait that ends at once never times out
		wait_done <= 1'h1; meas(1, ca); wait_done <= 1'h0;
		chk(ca, 600);
		pulse(16'h00e0, 4'h2); chk(width, 15);
		meas(1, ca); chk(ca, 600);
		wr(`TSQ_OFF_RUN, 16'h0000); wr(`TSQ_OFF_C0LIM, 16'h0002);
		rd(`TSQ_OFF_C0LIM); chk(v, 2);
		pulse(16'h0000, 4'h0); pulse(16'h0000, 4'h1); pulse(16'h0000, 4'h1);
		chk(c0_count, 2);
		chk(c0_at_limit, 1);
		rd(`TSQ_OFF_STAT); chk(v, 2);
		ticks(16'h0000, 6'h02, 0);
		ticks(16'h2000, 6'h02, 40);
		ticks(16'h0100, 6'h3f, 20);
		ticks(16'hc000, 6'h3f, 0);
		ticks(16'he000, 6'h3f, 0);
		report_and_stop;
	end
	// Hang guard, well past the expected run length
	initial begin
		#200000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
endmodule
